// ===== common/acs_map.vh
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
// control word field positions
`define ACS_CODE_MSB 5
`define ACS_CODE_LSB 3
`define ACS_CTRL_WIDTH 8
// frame timing in serial clock cycles
`define ACS_CONV_CYCLES 16
`define ACS_CAPTURE_EDGES 8
`define ACS_LEAD_ZEROS 4
`define ACS_RESULT_BITS 12
// reset values
`define ACS_CHAN_RESET 3'h0
`define ACS_SHIFT_RESET 8'h00
`endif

// ===== core/acs_channel_select.v
// Overview of operation
// - control word bits 7,6,2,1,0 are ignored
// - bits 5..3 choose channel for next conversion
// - channel code is plain binary index 0..7
// - each conversion spans sixteen serial clocks
// - first eight rising edges capture word MSB-first
// - four zeros then twelve result bits out
`timescale 1ns/100ps
`include "acs_map.vh"
module acs_channel_select #(
  parameter RESULT_BITS = `ACS_RESULT_BITS,
  parameter CHANNELS = 8
) (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // serial link pins
  input wire chip_select_n,
  input wire sclk,
  input wire din,
  output wire dout,
  output wire doutOe,
  // converter core side
  input wire [RESULT_BITS-1:0] convResult,
  output reg [2:0] activeChannel,
  output reg [CHANNELS-1:0] analogInputSel,
  output reg trackMode,
  output reg sampleStrobe,
  output reg convBusy,
  output reg powerUp
);
  wire csnS;
  wire sclkS;
  wire dinS;
  reg sclkQ_r;
  reg csnQ_r;
  reg [4:0] riseCnt_r;
  reg [4:0] fallCnt_r;
  reg [7:0] shiftIn_r;
  reg [2:0] nextChan_r;
  reg [RESULT_BITS-1:0] outShift_r;
  reg doutBit_r;
  wire riseEdge;
  wire fallEdge;
  wire frameOn;
  wire frameStart;
  wire riseCapture;
  wire riseLast;
  wire fallLast;
  wire fallHold;
  wire leadPhase;

  // synchronise all link pins; sclk must be well below ref_clk/6
  // chip select idles high; a low reset level would open a false frame
  acs_sync3 #(.RST_VAL(1'b1)) uCsn (
    .refClk(ref_clk),
    .sysRst(sys_rst),
    .pinIn(chip_select_n),
    .levelOut(csnS)
  );
  acs_sync3 uSclk (
    .refClk(ref_clk),
    .sysRst(sys_rst),
    .pinIn(sclk),
    .levelOut(sclkS)
  );
  acs_sync3 uDin (
    .refClk(ref_clk),
    .sysRst(sys_rst),
    .pinIn(din),
    .levelOut(dinS)
  );

  assign frameOn = ~csnS;
  // sclk gated off while deselected
  assign riseEdge = frameOn & sclkS & ~sclkQ_r;
  assign fallEdge = frameOn & ~sclkS & sclkQ_r;

  // positions within a conversion, decoded once and shared
  assign frameStart = frameOn & csnQ_r;
  assign riseCapture = riseEdge & (riseCnt_r == `ACS_CAPTURE_EDGES - 1);
  assign riseLast = riseEdge & (riseCnt_r == `ACS_CONV_CYCLES - 1);
  assign fallLast = fallEdge & (fallCnt_r == `ACS_CONV_CYCLES - 1);
  assign leadPhase = fallCnt_r < `ACS_LEAD_ZEROS;
  assign fallHold = fallEdge & (fallCnt_r == `ACS_LEAD_ZEROS - 1);

  // plain binary one-hot decode
  function [CHANNELS-1:0] decodeChan;
    input [2:0] code;
    begin
      decodeChan = {{(CHANNELS-1){1'b0}}, 1'b1} << code;
    end
  endfunction

  // pin history for edge and frame-start detection
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclkQ_r <= 1'b0;
      csnQ_r <= 1'b1;
    end else begin
      sclkQ_r <= sclkS;
      csnQ_r <= csnS;
    end
  end

  // rising edges within the current conversion
  // frame end or sixteenth rise restarts the count
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      riseCnt_r <= 5'h00;
    end else if (!frameOn || riseLast) begin
      riseCnt_r <= 5'h00;
    end else if (riseEdge) begin
      riseCnt_r <= riseCnt_r + 5'h01;
    end
  end

  // falling edges already seen; the current edge is fallCnt_r+1
  // a cut frame leaves no stale position for the next one
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fallCnt_r <= 5'h00;
    end else if (!frameOn || fallLast) begin
      fallCnt_r <= 5'h00;
    end else if (fallEdge) begin
      fallCnt_r <= fallCnt_r + 5'h01;
    end
  end

  // control word shifts in msb first on the first eight rises
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shiftIn_r <= `ACS_SHIFT_RESET;
    end else if (riseEdge && (riseCnt_r < `ACS_CAPTURE_EDGES)) begin
      shiftIn_r <= {shiftIn_r[6:0], dinS};
    end
  end

  // only bits 5..3 are kept; the rest never reach any logic
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nextChan_r <= `ACS_CHAN_RESET;
    end else if (riseCapture) begin
      nextChan_r <= shiftIn_r[`ACS_CODE_MSB-1:`ACS_CODE_LSB-1];
    end
  end

  // stored code applies at a frame start, or after rise 16 when
  // conversions run back to back inside one frame
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      activeChannel <= `ACS_CHAN_RESET;
      analogInputSel <= {{(CHANNELS-1){1'b0}}, 1'b1};
    end else if (frameStart || riseLast) begin
      activeChannel <= nextChan_r;
      analogInputSel <= decodeChan(nextChan_r);
    end
  end

  // result latched with the hold strobe, then shifted msb first
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outShift_r <= {RESULT_BITS{1'b0}};
    end else if (fallHold) begin
      outShift_r <= convResult;
    end else if (fallEdge && !leadPhase) begin
      outShift_r <= {outShift_r[RESULT_BITS-2:0], 1'b0};
    end
  end

  // four leading zeros, then twelve result bits on falls 5..16
  // deselected output parks low so a reselect starts clean
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      doutBit_r <= 1'b0;
    end else if (!frameOn) begin
      doutBit_r <= 1'b0;
    end else if (fallEdge && leadPhase) begin
      doutBit_r <= 1'b0;
    end else if (fallEdge) begin
      doutBit_r <= outShift_r[RESULT_BITS-1];
    end
  end

  // track from frame start or rise 16 until hold starts at fall 4
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trackMode <= 1'b0;
    end else if (!frameOn) begin
      trackMode <= 1'b0;
    end else if (frameStart || riseLast) begin
      trackMode <= 1'b1;
    end else if (fallHold) begin
      trackMode <= 1'b0;
    end
  end

  // hold strobe lasts one cycle; chip select high powers down
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sampleStrobe <= 1'b0;
      powerUp <= 1'b0;
    end else begin
      sampleStrobe <= fallHold;
      powerUp <= frameOn;
    end
  end

  // busy for the whole frame, continuous conversions included
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      convBusy <= 1'b0;
    end else if (!frameOn) begin
      convBusy <= 1'b0;
    end else if (frameStart) begin
      convBusy <= 1'b1;
    end
  end

  // active while selected, released while deselected
  assign dout = doutBit_r;
  assign doutOe = frameOn;
endmodule

// ===== core/acs_sync3.v
`timescale 1ns/100ps
// three-stage pin synchroniser; output changes once stages two and three agree
module acs_sync3 #(
  parameter [0:0] RST_VAL = 1'b0
) (
  // clock and reset
  input wire refClk,
  input wire sysRst,
  // pin in, clean level out
  input wire pinIn,
  output reg levelOut
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge refClk or posedge sysRst) begin
    if (sysRst) begin
      // reset to RST_VAL; only chip select sets it to its idle high level, sclk and din reset low
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      levelOut <= RST_VAL;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        levelOut <= s3_r;
      end
    end
  end
endmodule

// ===== testbench/acs_channel_select_chk.sv
`timescale 1ns/100ps
module acs_channel_select_chk #(parameter CHANNELS = 8) (
  // clock, reset
  input wire ref_clk,
  input wire sys_rst,
  // watched pins
  input wire chip_select_n,
  input wire dout,
  input wire doutOe,
  input wire [2:0] activeChannel,
  input wire [CHANNELS-1:0] analogInputSel,
  input wire trackMode,
  input wire sampleStrobe,
  input wire convBusy,
  input wire powerUp
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_idle; chip_select_n [*8]; endsequence
  property p_sel; analogInputSel == 1 << activeChannel; endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_hold; $changed(activeChannel) |-> trackMode && doutOe; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_busy; doutOe == $past(doutOe) |-> convBusy == doutOe; endproperty
  a_busy: assert property (p_busy) else $error("busy");
  property p_pulse; sampleStrobe |=> !sampleStrobe; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  property p_conv; sampleStrobe |=> !trackMode; endproperty
  a_conv: assert property (p_conv) else $error("track");
  property p_zero; sampleStrobe |-> !dout ##1 !dout; endproperty
  a_zero: assert property (p_zero) else $error("zeros");
  property p_off; s_idle |-> !doutOe && !powerUp; endproperty
  a_off: assert property (p_off) else $error("idle");
  property p_quiet; !doutOe |-> !sampleStrobe; endproperty
  a_quiet: assert property (p_quiet) else $error("quiet");
  property p_start; $rose(doutOe) |-> ##[0:2] trackMode; endproperty
  a_start: assert property (p_start) else $error("start");
endmodule
bind acs_channel_select acs_channel_select_chk #(.CHANNELS(CHANNELS)) u_chk (.*);

// ===== testbench/acs_mst_model.sv
`timescale 1ns/100ps
module acs_mst_model (
  // clock
  input wire refClk,
  // link
  output logic sclk = 1,
  output logic din = 0,
  input wire dout
);
  // slow link: pins are sampled, not used as clocks
  task automatic hw; repeat (8) @(posedge refClk); #1; endtask
  task automatic conv(input [7:0] w, output [11:0] r);
    for (int i = 0; i < 16; i++) begin
      sclk = 0;
      din = i < 8 ? w[7-i] : ~din;
      hw;
      sclk = 1;
      hw;
      if (i > 3) r = {r[10:0], dout};
    end
  endtask
endmodule

// ===== testbench/tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module tb;
  logic ref_clk = 0, sys_rst = 1, csN = 1;
  wire sclk, din, dout, doutOe;
  wire [2:0] ch;
  wire [7:0] sel;
  wire [11:0] res = {ch, 9'h15a};
  logic [11:0] r;
  int errors = 0, tests_run = 0;
  initial forever #5 ref_clk = ~ref_clk;
  acs_channel_select u_acs_channel_select (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .chip_select_n(csN), .sclk(sclk), .din(din), .dout(dout), .doutOe(doutOe),
    .convResult(res), .activeChannel(ch), .analogInputSel(sel), .trackMode(),
    .sampleStrobe(), .convBusy(), .powerUp());
  acs_mst_model u_mst (.refClk(ref_clk), .sclk(sclk), .din(din), .dout(dout));
  task automatic wrap_up;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic frame_open;
    @(posedge ref_clk); #1 csN = 0;
    for (int i = 0; i < 20 && doutOe !== 1; i++) begin @(posedge ref_clk); #1; end
    if (doutOe !== 1) begin errors++; wrap_up; end
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic frame_close;
    @(posedge ref_clk); #1 csN = 1;
    repeat (12) @(posedge ref_clk);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 0;
    `CHK(sel, 8'h01)
    for (int k = 0; k < 9; k++) begin
      frame_open;
      if (k > 0) `CHK(sel, 8'h01 << (k - 1))
      u_mst.conv({k[1:0] ^ 2'h2, k[2:0], ~k[2:0]}, r);
      if (k > 0) `CHK(r, {k[2:0] - 3'h1, 9'h15a})
      frame_close;
    end
    frame_open;
    u_mst.conv(8'h1b, r);
    `CHK(r, 12'h15a)
    u_mst.conv(8'h30, r);
    `CHK(r, {3'h3, 9'h15a})
    frame_close;
    frame_open;
    `CHK(ch, 3'h6)
    frame_close;
    wrap_up;
  end
endmodule
